// ---- src/hsdc_pkg.sv ----
// Purpose: constants for the high-side driver control block
// Assumes: 32-bit Avalon-MM word registers, 8-bit data in low bits
// Notes: offsets are byte addresses, one word per register
package hsdc_pkg;
  localparam int HSDC_NDRV = 2;
  localparam logic [3:0] HSDC_OFF_DATA = 4'h0;
  localparam logic [3:0] HSDC_OFF_CFG = 4'h4;
  localparam logic [3:0] HSDC_OFF_STAT = 4'h8;
  localparam logic [3:0] HSDC_OFF_IE = 4'hC;
  localparam logic [3:0] HSDC_OFF_IF = 4'h0;
  localparam logic [4:0] HSDC_OFF_IF_FULL = 5'h10;
  localparam int HSDC_CFG_EN_LSB = 0;
  localparam int HSDC_CFG_OLE_LSB = 2;
  localparam int HSDC_IE_BIT = 7;
  localparam logic [1:0] HSDC_RST_2B = 2'h0;
  localparam logic [31:0] HSDC_RD_ZERO = 32'h0000_0000;
endpackage

// ---- src/hsdc_top.sv ----
// Function
// RQ1 - interrupt requested when enable is 1 and any over-current flag set
// RQ2 - writing 1 clears a flag; writing 0 leaves it unchanged
// RQ3 - over-current event sets that driver's flag, bits 1-0
// RQ4 - gate forced off while its flag is set
// RQ5 - after flag clears, gate follows the selected source again
// RQ6 - over-current detection works only while driver is enabled
// RQ7 - gate source is data bit or routed timer/pwm by route select
// RQ8 - open-load detection has a per-driver enable bit
// RQ9 - open-load check only when enabled and source commands gate off
// RQ10 - pin above threshold during check reports open load
// RQ11 - open-load status has one bit per driver
// RQ12 - over-current forcing alone does not start open-load check
// RQ13 - interrupt delivered only in run mode
// RQ14 - stop mode entry or exit leaves flags unchanged
// RQ15 - stop mode entry clears both gate data bits
// RQ16 - data read gives stored bit if disabled, routed source if enabled
// RQ17 - enable bit switches driver supply on or off
// RQ18 - module interrupt is enable AND OR of both flags
// Purpose: control and protection logic for two high-side drivers
// Assumes: all inputs synchronous to clk_i; 125 MHz clock
// Notes: registers on Avalon-MM; waitrequest low one cycle after request
`timescale 1ns/10ps
module hsdc_top
  import hsdc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [1:0] route_sel_alt_i,
  input wire logic [1:0] alt_source_i,
  input wire logic [1:0] overcurrent_event_i,
  input wire logic [1:0] openload_comp_i,
  input wire logic stop_mode_i,
  output logic [1:0] gate_on_o,
  output logic [1:0] driver_supply_on_o,
  output logic [1:0] openload_check_active_o,
  output logic driver_module_interrupt_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] gate_data;
    logic [1:0] driver_enable;
    logic [1:0] openload_detect_enable;
    logic [1:0] openload_status;
    logic irq_enable;
    logic [1:0] overcurrent_flag;
    logic stop_d;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] gate;
    logic irq;
  } hsdc_state_t;

  hsdc_state_t st_reg;
  hsdc_state_t st_next;

  logic req;
  logic do_wr;
  logic do_rd;
  logic [1:0] src_cmd;
  logic [1:0] ol_active;
  logic [1:0] oc_set;
  logic [1:0] oc_clr;
  logic [7:0] rd_byte;

  function automatic logic [1:0] hsdc_w1c(input logic [1:0] flags, input logic [1:0] set_v, input logic [1:0] clr_v);
    hsdc_w1c = set_v | (flags & ~clr_v);
  endfunction

  assign req = avs_read_i | avs_write_i;
  // write lands at the accepting edge, where waitrequest is low
  assign do_wr = avs_write_i & st_reg.ack;
  assign do_rd = avs_read_i & ~st_reg.ack;
  assign avs_waitrequest_o = req & ~st_reg.ack;
  assign avs_readdata_o = st_reg.rdata;
  assign gate_on_o = st_reg.gate;
  assign driver_supply_on_o = st_reg.driver_enable; // [RQ17]
  assign openload_check_active_o = ol_active;
  assign driver_module_interrupt_o = st_reg.irq;

  // ---------------------------------------------------------------
  // source selection and detection
  // ---------------------------------------------------------------
  always_comb begin
    src_cmd = (route_sel_alt_i & alt_source_i) | (~route_sel_alt_i & st_reg.gate_data); // [RQ7]
    // the forced-off state is ignored here on purpose
    ol_active = st_reg.openload_detect_enable & st_reg.driver_enable & ~src_cmd; // [RQ8] [RQ9] [RQ12]
    oc_set = overcurrent_event_i & st_reg.driver_enable; // [RQ6]
    oc_clr = 2'h0;
    if (do_wr && avs_address_i == HSDC_OFF_IF_FULL && avs_byteenable_i[0]) begin
      oc_clr = avs_writedata_i[1:0]; // [RQ2]
    end
    case (avs_address_i)
      {1'b0, HSDC_OFF_DATA}: rd_byte = {6'h00, (st_reg.driver_enable & src_cmd)
                                        | (~st_reg.driver_enable & st_reg.gate_data)}; // [RQ16]
      {1'b0, HSDC_OFF_CFG}: rd_byte = {4'h0, st_reg.openload_detect_enable, st_reg.driver_enable};
      {1'b0, HSDC_OFF_STAT}: rd_byte = {6'h00, st_reg.openload_status}; // [RQ11]
      {1'b0, HSDC_OFF_IE}: rd_byte = {st_reg.irq_enable, 7'h00};
      HSDC_OFF_IF_FULL: rd_byte = {6'h00, st_reg.overcurrent_flag};
      default: rd_byte = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.ack = req & ~st_reg.ack;
    st_next.stop_d = stop_mode_i;
    if (do_rd) begin
      st_next.rdata = {24'h00_0000, rd_byte};
    end
    if (do_wr && avs_byteenable_i[0]) begin
      case (avs_address_i)
        {1'b0, HSDC_OFF_DATA}: st_next.gate_data = avs_writedata_i[1:0];
        {1'b0, HSDC_OFF_CFG}: begin
          st_next.driver_enable = avs_writedata_i[HSDC_CFG_EN_LSB +: 2];
          st_next.openload_detect_enable = avs_writedata_i[HSDC_CFG_OLE_LSB +: 2];
        end
        {1'b0, HSDC_OFF_IE}: st_next.irq_enable = avs_writedata_i[HSDC_IE_BIT];
        default: st_next.rdata = st_next.rdata;
      endcase
    end
    if (stop_mode_i && !st_reg.stop_d) begin
      st_next.gate_data = HSDC_RST_2B; // [RQ15]
    end
    // set wins over a same-cycle clear; stop mode does not touch flags
    st_next.overcurrent_flag = hsdc_w1c(st_reg.overcurrent_flag, oc_set, oc_clr); // [RQ3] [RQ2] [RQ14]
    st_next.openload_status = ol_active & openload_comp_i; // [RQ10]
    st_next.gate = src_cmd & st_reg.driver_enable & ~st_next.overcurrent_flag; // [RQ4] [RQ5]
    st_next.irq = st_reg.irq_enable & (|st_next.overcurrent_flag) & ~stop_mode_i; // [RQ1] [RQ13] [RQ18]
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_irq_follows_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.irq_enable && |st_reg.overcurrent_flag && !stop_mode_i && !$past(stop_mode_i))
      |-> driver_module_interrupt_o || $past(!st_reg.irq_enable)) else $error("irq missing"); // [RQ1]
  chk_irq_disabled: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(!st_reg.irq_enable) |-> !driver_module_interrupt_o) else $error("irq while disabled"); // [RQ18]
  chk_irq_run_only: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(stop_mode_i) |-> !driver_module_interrupt_o) else $error("irq in stop"); // [RQ13]
  chk_flag_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    (overcurrent_event_i[0] && st_reg.driver_enable[0]) |=> st_reg.overcurrent_flag[0])
    else $error("flag not set"); // [RQ3]
  chk_flag_needs_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    (!st_reg.overcurrent_flag[1] && !(overcurrent_event_i[1] && st_reg.driver_enable[1]))
      |=> !st_reg.overcurrent_flag[1]) else $error("flag without enabled event"); // [RQ6]
  chk_flag_w1c: assert property (@(posedge clk_i) disable iff (rst_i)
    (oc_clr[0] && !oc_set[0]) |=> !st_reg.overcurrent_flag[0]) else $error("w1c failed"); // [RQ2]
  chk_gate_forced_off: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg.overcurrent_flag[0] |-> !gate_on_o[0]) else $error("gate on with flag"); // [RQ4]
  chk_gate_returns: assert property (@(posedge clk_i) disable iff (rst_i)
    (!st_next.overcurrent_flag[1] && st_reg.driver_enable[1] && src_cmd[1]) |=> gate_on_o[1])
    else $error("gate not returned"); // [RQ5]
  chk_openload_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    openload_check_active_o[1] |-> !src_cmd[1]) else $error("open-load check while source on"); // [RQ9]
  chk_openload_cond: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg.openload_status[0] |-> $past(st_reg.driver_enable[0] && st_reg.openload_detect_enable[0]
      && openload_comp_i[0])) else $error("open load without check"); // [RQ10]
  chk_stop_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(stop_mode_i) |=> st_reg.gate_data == 2'h0) else $error("stop did not clear data"); // [RQ15]

  // ---------------------------------------------------------------
  // bus checks
  // ---------------------------------------------------------------
  chk_wait_first: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(req) |-> avs_waitrequest_o)
    else $error("no wait state on new request");

  chk_wait_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && avs_waitrequest_o) ##1 req |-> !avs_waitrequest_o)
    else $error("request not answered");

  chk_idle_no_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    !req |-> !avs_waitrequest_o)
    else $error("waitrequest while idle");

  chk_rdata_stands: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(do_rd) |-> $stable(avs_readdata_o))
    else $error("read data moved without read");

  chk_rd_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    avs_readdata_o[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");

  chk_rd_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
    (do_rd && avs_address_i == 5'h14) |=> avs_readdata_o == HSDC_RD_ZERO)
    else $error("unmapped read not zero");

  chk_rd_status: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ11]
    (do_rd && avs_address_i == {1'b0, HSDC_OFF_STAT}) |=> avs_readdata_o[1:0] == $past(st_reg.openload_status))
    else $error("status read wrong");

  chk_rd_data_disabled: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ16]
    (do_rd && avs_address_i == {1'b0, HSDC_OFF_DATA} && !st_reg.driver_enable[0])
      |=> avs_readdata_o[0] == $past(st_reg.gate_data[0])) else $error("stored data bit not read");

  chk_rd_data_enabled: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ16]
    (do_rd && avs_address_i == {1'b0, HSDC_OFF_DATA} && st_reg.driver_enable[1])
      |=> avs_readdata_o[1] == $past(src_cmd[1])) else $error("routed source not read");

  chk_supply_write: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ17]
    (do_wr && avs_byteenable_i[0] && avs_address_i == {1'b0, HSDC_OFF_CFG})
      |=> driver_supply_on_o == $past(avs_writedata_i[1:0])) else $error("supply not switched");

  chk_ie_write: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ1]
    (do_wr && avs_byteenable_i[0] && avs_address_i == {1'b0, HSDC_OFF_IE})
      |=> st_reg.irq_enable == $past(avs_writedata_i[HSDC_IE_BIT])) else $error("irq enable not written");

  // ---------------------------------------------------------------
  // flag checks
  // ---------------------------------------------------------------
  chk_flag_sets_drv1: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ3]
    (overcurrent_event_i[1] && st_reg.driver_enable[1]) |=> st_reg.overcurrent_flag[1])
    else $error("flag 1 not set");

  chk_flag_holds: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ2]
    (st_reg.overcurrent_flag[0] && !oc_clr[0]) |=> st_reg.overcurrent_flag[0])
    else $error("flag lost without clear");

  chk_flag_w1c_drv1: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ2]
    (oc_clr[1] && !oc_set[1]) |=> !st_reg.overcurrent_flag[1])
    else $error("flag 1 not cleared");

  chk_flag_needs_en0: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ6]
    (!st_reg.overcurrent_flag[0] && !(overcurrent_event_i[0] && st_reg.driver_enable[0]))
      |=> !st_reg.overcurrent_flag[0]) else $error("flag 0 without enabled event");

  chk_flag_stop_entry: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ14]
    ($rose(stop_mode_i) && st_reg.overcurrent_flag[0] && !oc_clr[0]) |=> st_reg.overcurrent_flag[0])
    else $error("stop entry changed flag");

  chk_flag_stop_exit: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ14]
    ($fell(stop_mode_i) && !st_reg.overcurrent_flag[1] && !oc_set[1]) |=> !st_reg.overcurrent_flag[1])
    else $error("stop exit changed flag");

  // ---------------------------------------------------------------
  // gate checks
  // ---------------------------------------------------------------
  chk_gate_forced_drv1: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ4]
    st_reg.overcurrent_flag[1] |-> !gate_on_o[1])
    else $error("gate 1 on with flag");

  chk_gate_returns_drv0: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ5]
    (!st_next.overcurrent_flag[0] && st_reg.driver_enable[0] && src_cmd[0]) |=> gate_on_o[0])
    else $error("gate 0 not returned");

  chk_gate_src_data: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ7]
    (!route_sel_alt_i[0] && st_reg.driver_enable[0] && !st_next.overcurrent_flag[0])
      |=> gate_on_o[0] == $past(st_reg.gate_data[0])) else $error("gate 0 not following data");

  chk_gate_src_alt: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ7]
    (route_sel_alt_i[1] && st_reg.driver_enable[1] && !st_next.overcurrent_flag[1])
      |=> gate_on_o[1] == $past(alt_source_i[1])) else $error("gate 1 not following routed source");

  chk_gate_needs_supply: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ17]
    !$past(st_reg.driver_enable[0]) |-> !gate_on_o[0])
    else $error("gate on without supply");

  // ---------------------------------------------------------------
  // open-load checks
  // ---------------------------------------------------------------
  chk_ol_needs_enable: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ8]
    openload_check_active_o[1] |-> (st_reg.openload_detect_enable[1] && st_reg.driver_enable[1]))
    else $error("open-load check without enables");

  chk_ol_source_off: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ9]
    openload_check_active_o[0] |-> !src_cmd[0])
    else $error("open-load check while source 0 on");

  chk_ol_ignores_force: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ12]
    (st_reg.overcurrent_flag[0] && src_cmd[0]) |-> !openload_check_active_o[0])
    else $error("forced gate started open-load check");

  chk_ol_reports: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ10]
    (openload_check_active_o[1] && openload_comp_i[1]) |=> st_reg.openload_status[1])
    else $error("open load not reported");

  chk_ol_clears: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ10]
    !openload_check_active_o[0] |=> !st_reg.openload_status[0])
    else $error("open load reported without check");

endmodule

// ---- tb/hsdc_tb_top.sv ----
// Purpose: self-checking bench for hsdc_top
// Assumes: Avalon-MM slave with waitrequest, 125 MHz clock
// Notes: every scenario drives ports by non-blocking assignment after a rising edge
`timescale 1ns/10ps
module hsdc_tb_top;
  import hsdc_pkg::*;
  logic clk_i = 0, rst_i = 1, avs_read_i = 0, avs_write_i = 0, stop_mode_i = 0;
  logic [4:0] avs_address_i = '0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_writedata_i = '0, avs_readdata_o, q;
  logic [1:0] route_sel_alt_i = '0, alt_source_i = '0, overcurrent_event_i = '0, openload_comp_i = '0;
  logic [1:0] gate_on_o, driver_supply_on_o, openload_check_active_o;
  logic avs_waitrequest_o, driver_module_interrupt_o;
  int num_errors = 0, total_checks = 0;
  localparam logic [4:0] AD = {1'b0, HSDC_OFF_DATA}, AC = {1'b0, HSDC_OFF_CFG};
  localparam logic [4:0] AS = {1'b0, HSDC_OFF_STAT}, AE = {1'b0, HSDC_OFF_IE}, AF = HSDC_OFF_IF_FULL;
  hsdc_top u_dut (.clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .route_sel_alt_i, .alt_source_i,
    .overcurrent_event_i, .openload_comp_i, .stop_mode_i, .gate_on_o, .driver_supply_on_o,
    .openload_check_active_o, .driver_module_interrupt_o);
  initial forever #4 clk_i = ~clk_i;
  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is seen low before the accepting edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    {avs_write_i, avs_read_i} <= {w, !w};
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 40);
    if (n >= 40) num_errors++;
    q = avs_readdata_o;
    {avs_write_i, avs_read_i} <= 2'b00;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  task automatic ck();
    repeat (3) @(negedge clk_i);
  endtask
  task automatic oc(input logic [1:0] v);
    @(posedge clk_i) overcurrent_event_i <= v;
    @(posedge clk_i) overcurrent_event_i <= 2'b00;
    ck();
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk({gate_on_o, driver_supply_on_o, openload_check_active_o, driver_module_interrupt_o}, 0);
    rd(AC, 32'h0000_0000);
    rd(AF, 32'h0000_0000);
    rd(5'h14, 32'h0000_0000);
    $display("t_reset done");
  endtask
  task automatic t_gate();
    wr(AC, 32'h0000_0003);
    ck();
    chk(driver_supply_on_o, 2'b11);
    @(posedge clk_i) {route_sel_alt_i, alt_source_i} <= 4'b1010;
    wr(AD, 32'h0000_0001);
    ck();
    chk(gate_on_o, 2'b11);
    rd(AD, 32'h0000_0003);
    @(posedge clk_i) alt_source_i <= 2'b00;
    ck();
    chk(gate_on_o, 2'b01);
    wr(AC, 32'h0000_0000);
    rd(AD, 32'h0000_0001);
    $display("t_gate done");
  endtask
  task automatic t_oc();
    @(posedge clk_i) route_sel_alt_i <= 2'b00;
    wr(AC, 32'h0000_0001);
    oc(2'b10);
    rd(AF, 32'h0000_0000);
    wr(AE, 32'h0000_0080);
    rd(AE, 32'h0000_0080);
    oc(2'b01);
    chk(gate_on_o, 2'b00);
    chk(driver_module_interrupt_o, 1'b1);
    rd(AF, 32'h0000_0001);
    @(posedge clk_i) stop_mode_i <= 1'b1;
    ck();
    chk(driver_module_interrupt_o, 1'b0);
    @(posedge clk_i) stop_mode_i <= 1'b0;
    rd(AF, 32'h0000_0001);
    rd(AD, 32'h0000_0000);
    wr(AD, 32'h0000_0001);
    wr(AF, 32'h0000_0002);
    rd(AF, 32'h0000_0001);
    wr(AE, 32'h0000_0000);
    ck();
    chk(driver_module_interrupt_o, 1'b0);
    wr(AF, 32'h0000_0001);
    rd(AF, 32'h0000_0000);
    ck();
    chk(gate_on_o, 2'b01);
    $display("t_oc done");
  endtask
  task automatic t_ol();
    wr(AC, 32'h0000_000F);
    ck();
    chk(openload_check_active_o, 2'b10);
    wr(AD, 32'h0000_0000);
    ck();
    chk(openload_check_active_o, 2'b11);
    @(posedge clk_i) openload_comp_i <= 2'b10;
    ck();
    rd(AS, 32'h0000_0002);
    wr(AD, 32'h0000_0003);
    oc(2'b11);
    chk({gate_on_o, openload_check_active_o}, 4'b0000);
    wr(AF, 32'h0000_0003);
    $display("t_ol done");
  endtask
  task automatic end_sim();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #100us;
    num_errors++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_gate();
    t_oc();
    t_ol();
    end_sim();
  end
endmodule
